// ===== common/spcr_defines.svh
// Purpose: constants of the serial port configuration register block
// Assumes: included by bare name wherever offsets, fields or resets are needed
// Notes: definitions only
`ifndef SPCR_DEFINES_SVH
`define SPCR_DEFINES_SVH

// ==========================================
// frame layout
`define SPCR_INSTR_LAST 4'hf
`define SPCR_BYTE_LAST 3'h7
`define SPCR_INSTR_RD_BIT 15
`define SPCR_ADDR_MSB 12

// ==========================================
// register offsets
`define SPCR_ADDR_CONFIG 13'h000
`define SPCR_ADDR_REVISION 13'h002
`define SPCR_ADDR_VARIANT 13'h003
`define SPCR_ADDR_BANKSEL 13'h004
`define SPCR_ADDR_USER_BASE 13'h010

// ==========================================
// field positions
`define SPCR_CFG_DIR_BIT 7
`define SPCR_CFG_ORDER_BIT 6
`define SPCR_CFG_SRST_BIT 5
`define SPCR_BANKSEL_BIT 0
`define SPCR_CFG_DIR_MIR_BIT 0
`define SPCR_CFG_ORDER_MIR_BIT 1
`define SPCR_CFG_SRST_MIR_BIT 2

// ==========================================
// reset values
`define SPCR_CFG_DIR_RESET 1'h0
`define SPCR_CFG_ORDER_RESET 1'h0
`define SPCR_CFG_SRST_RESET 1'h0
`define SPCR_BANKSEL_RESET 1'h0
`define SPCR_USER_RESET 8'h00
`define SPCR_READ_ZERO 8'h00

`endif

// ===== common/spcr_pkg.sv
// Purpose: shared types of the serial port configuration register block
// Assumes: nothing beyond the defines header
// Notes: types only; numbers live in spcr_defines.svh
package spcr_pkg;

    // ==========================================
    // phase of a serial frame
    typedef enum logic [1:0] {
        SPCR_PH_INSTR = 2'b00,
        SPCR_PH_WRITE = 2'b01,
        SPCR_PH_READ = 2'b10
    } spcr_phase_t;

    typedef logic [7:0] spcr_byte_t;

endpackage

// ===== src/spcr_sync.sv
// Purpose: two flip-flop synchroniser for levels and toggles
// Assumes: input changes slowly compared with the destination clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module spcr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // destination clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // level in and synchronised level out
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_r;

    // ==========================================
    // two stages, only the second stage reads the first one
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_r <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end

endmodule

// ===== src/spcr_top.sv
// Purpose: serial port configuration, identification and bank readback registers
// Assumes: host shifts on i_sclk rising edges; frame bounded by i_csb_n low
// Notes: link logic runs on i_sclk, the active bank runs on i_clk
//
// Notes on behaviour
// - direction 0: data pin both ways, serial out floats
// - direction 1: reads leave on serial out pin
// - order 0: msb first, address decrements in spi and increments in i2c
// - order 1: lsb first, address increments
// - i2c mode ignores the bit order setting
// - soft reset bit restores default bank select, buffer and active register values
// - spi: soft reset clears next link clock
// - spi: soft reset keeps config register contents
// - i2c: soft reset clears next link clock
// - read-only revision register ignores writes
// - read-only variant identification register
// - select 0 reads back buffer registers
// - select 1 reads back active registers
`timescale 1ns/1ns
module spcr_top
    import spcr_pkg::*;
#(
    parameter int USER_COUNT = 4,
    parameter logic [7:0] REVISION_ID = 8'h01,  // arbitrary value
    parameter logic [7:0] VARIANT_CODE = 8'h5a  // arbitrary value
) (
    // system clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // serial link, clocked by the host
    input wire logic i_sclk,
    input wire logic i_csb_n,
    input wire logic i_data_pin_in,
    output logic o_data_pin_out,
    output logic o_data_pin_oe,
    output logic o_serial_out,
    output logic o_serial_out_oe,
    // port mode strap and update action
    input wire logic i_i2c_mode,
    input wire logic i_update,
    // active bank and soft reset towards the device
    output logic [USER_COUNT*8-1:0] o_user_active,
    output logic o_soft_reset
);
`include "spcr_defines.svh"

    localparam int IDX_W = (USER_COUNT > 1) ? $clog2(USER_COUNT) : 1;
    localparam logic [12:0] USER_COUNT_A = 13'(USER_COUNT);

    // ==========================================
    // link domain state
    spcr_phase_t phase_r;
    logic [3:0] bit_cnt_r;
    logic [15:0] shift_r;
    logic [12:0] addr_r;
    logic [7:0] tx_r;
    logic cfg_dir_r;
    logic cfg_order_r;
    logic cfg_srst_r;
    logic banksel_r;
    logic srst_tgl_r;
    logic [USER_COUNT*8-1:0] user_buf_r;
    logic i2c_mode_s;

    // ==========================================
    // core domain state
    logic [USER_COUNT*8-1:0] user_act_r;
    logic upd_pend_r;
    logic upd_d_r;
    logic tgl_d_r;
    logic soft_reset_r;
    logic idle_s;
    logic upd_s;
    logic tgl_s;

    // ==========================================
    // link combinational terms
    logic frame_rstn;
    logic lsb_first;
    logic addr_incr;
    logic [15:0] shift_nxt;
    logic instr_done;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [12:0] addr_step;
    logic [12:0] addr_nxt;
    logic [12:0] rd_addr;
    logic [7:0] rd_byte;
    logic wr_en;
    logic wr_user;
    logic [IDX_W-1:0] wr_idx;
    logic [12:0] wr_off;
    logic [12:0] rd_off;

    // frame logic is held in reset whenever chip select is high
    assign frame_rstn = i_rstn & ~i_csb_n;

    // the strap is static in use; sampled on the link clock it owns
    spcr_sync #(
        .WIDTH(1),
        .RST_VAL(1'h0)
    ) u_sync_mode (
        .i_clk(i_sclk),
        .i_rstn(i_rstn),
        .i_d(i_i2c_mode),
        .o_q(i2c_mode_s)
    );

    // bit order and address step
    assign lsb_first = cfg_order_r & ~i2c_mode_s;
    assign addr_incr = lsb_first | i2c_mode_s;
    assign addr_step = addr_incr ? 13'(addr_r + 13'h001) : 13'(addr_r - 13'h001);

    // one shift register serves the instruction and every data byte
    assign shift_nxt = lsb_first ? {i_data_pin_in, shift_r[15:1]} : {shift_r[14:0], i_data_pin_in};
    assign rx_byte = lsb_first ? shift_nxt[15:8] : shift_nxt[7:0];
    assign instr_done = (phase_r == SPCR_PH_INSTR) && (bit_cnt_r == `SPCR_INSTR_LAST);
    assign byte_done = (phase_r != SPCR_PH_INSTR) && (bit_cnt_r[2:0] == `SPCR_BYTE_LAST);
    assign addr_nxt = shift_nxt[`SPCR_ADDR_MSB:0];
    assign rd_addr = instr_done ? addr_nxt : addr_step;
    assign wr_en = byte_done && (phase_r == SPCR_PH_WRITE);

    // user bank decode for writes
    assign wr_off = 13'(addr_r - `SPCR_ADDR_USER_BASE);
    assign wr_user = (addr_r >= `SPCR_ADDR_USER_BASE) && (wr_off < USER_COUNT_A);
    assign wr_idx = wr_off[IDX_W-1:0];
    assign rd_off = 13'(rd_addr - `SPCR_ADDR_USER_BASE);

    // ==========================================
    // read multiplexer
    // the active bank belongs to i_clk; an update only copies into it while chip
    // select is idle, but a soft reset clears it even while a frame is running
    always_comb begin
        rd_byte = `SPCR_READ_ZERO;
        case (rd_addr)
            `SPCR_ADDR_CONFIG: begin
                rd_byte[`SPCR_CFG_DIR_BIT] = cfg_dir_r;
                rd_byte[`SPCR_CFG_ORDER_BIT] = cfg_order_r;
                rd_byte[`SPCR_CFG_SRST_BIT] = cfg_srst_r;
                rd_byte[`SPCR_CFG_SRST_MIR_BIT] = cfg_srst_r;  // mirror of bit 5
                rd_byte[`SPCR_CFG_ORDER_MIR_BIT] = cfg_order_r;  // mirror of bit 6
                rd_byte[`SPCR_CFG_DIR_MIR_BIT] = cfg_dir_r;  // mirror of bit 7
            end
            `SPCR_ADDR_REVISION: begin
                rd_byte = REVISION_ID;
            end
            `SPCR_ADDR_VARIANT: begin
                rd_byte = VARIANT_CODE;
            end
            `SPCR_ADDR_BANKSEL: begin
                rd_byte[`SPCR_BANKSEL_BIT] = banksel_r;
            end
            default: begin
                if ((rd_addr >= `SPCR_ADDR_USER_BASE) && (rd_off < USER_COUNT_A)) begin
                    if (banksel_r) begin
                        rd_byte = user_act_r[rd_off[IDX_W-1:0]*8 +: 8];
                    end else begin
                        rd_byte = user_buf_r[rd_off[IDX_W-1:0]*8 +: 8];
                    end
                end
            end
        endcase
    end

    // ==========================================
    // frame sequencing on the link clock
    always_ff @(posedge i_sclk or negedge frame_rstn) begin
        if (!frame_rstn) begin
            phase_r <= SPCR_PH_INSTR;
            bit_cnt_r <= 4'h0;
            shift_r <= 16'h0000;
            addr_r <= 13'h0000;
        end else begin
            shift_r <= shift_nxt;
            case (phase_r)
                SPCR_PH_INSTR: begin
                    bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
                    if (instr_done) begin
                        addr_r <= addr_nxt;
                        phase_r <= shift_nxt[`SPCR_INSTR_RD_BIT] ? SPCR_PH_READ : SPCR_PH_WRITE;
                    end
                end
                SPCR_PH_WRITE, SPCR_PH_READ: begin
                    bit_cnt_r <= {1'h0, 3'(bit_cnt_r[2:0] + 3'h1)};
                    if (byte_done) begin
                        addr_r <= addr_step;  // streaming steps the address
                    end
                end
                default: begin
                    phase_r <= SPCR_PH_INSTR;
                end
            endcase
        end
    end

    // ==========================================
    // read data: loaded after the instruction and after each read byte
    always_ff @(posedge i_sclk or negedge frame_rstn) begin
        if (!frame_rstn) begin
            tx_r <= 8'h00;
        end else if (instr_done || (byte_done && (phase_r == SPCR_PH_READ))) begin
            tx_r <= rd_byte;
        end else if (lsb_first) begin
            tx_r <= {1'h0, tx_r[7:1]};
        end else begin
            tx_r <= {tx_r[6:0], 1'h0};
        end
    end

    // ==========================================
    // pin drivers change on the falling edge so the host samples on rising
    always_ff @(negedge i_sclk or negedge frame_rstn) begin
        if (!frame_rstn) begin
            o_data_pin_out <= 1'h0;
            o_data_pin_oe <= 1'h0;
            o_serial_out <= 1'h0;
            o_serial_out_oe <= 1'h0;
        end else if (phase_r == SPCR_PH_READ) begin
            if (cfg_dir_r) begin
                o_serial_out <= lsb_first ? tx_r[0] : tx_r[7];
                o_serial_out_oe <= 1'h1;
                o_data_pin_out <= 1'h0;
                o_data_pin_oe <= 1'h0;  // write-only data pin
            end else begin
                o_data_pin_out <= lsb_first ? tx_r[0] : tx_r[7];
                o_data_pin_oe <= 1'h1;
                o_serial_out <= 1'h0;
                o_serial_out_oe <= 1'h0;  // floats
            end
        end else begin
            o_data_pin_out <= 1'h0;
            o_data_pin_oe <= 1'h0;
            o_serial_out <= 1'h0;
            o_serial_out_oe <= 1'h0;
        end
    end

    // ==========================================
    // configuration register; soft reset never touches it
    always_ff @(posedge i_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_dir_r <= `SPCR_CFG_DIR_RESET;
            cfg_order_r <= `SPCR_CFG_ORDER_RESET;
            cfg_srst_r <= `SPCR_CFG_SRST_RESET;
        end else if (wr_en && (addr_r == `SPCR_ADDR_CONFIG)) begin
            cfg_dir_r <= rx_byte[`SPCR_CFG_DIR_BIT];
            cfg_order_r <= rx_byte[`SPCR_CFG_ORDER_BIT];  // low nibble is host's mirror
            cfg_srst_r <= rx_byte[`SPCR_CFG_SRST_BIT];
        end else if (cfg_srst_r) begin
            cfg_srst_r <= 1'h0;  // self-clear on the next link edge
        end
    end

    // ==========================================
    // buffer bank and readback select; the restore edge flips a toggle
    always_ff @(posedge i_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            banksel_r <= `SPCR_BANKSEL_RESET;
            user_buf_r <= {USER_COUNT{`SPCR_USER_RESET}};
            srst_tgl_r <= 1'h0;
        end else if (cfg_srst_r) begin
            banksel_r <= `SPCR_BANKSEL_RESET;
            user_buf_r <= {USER_COUNT{`SPCR_USER_RESET}};
            srst_tgl_r <= ~srst_tgl_r;  // tells the core bank to restore
        end else if (wr_en) begin
            if (addr_r == `SPCR_ADDR_BANKSEL) begin
                banksel_r <= rx_byte[`SPCR_BANKSEL_BIT];  // upper bits dropped
            end else if (wr_user) begin
                user_buf_r[wr_idx*8 +: 8] <= rx_byte;  // writes stage only
            end
        end
    end

    // ==========================================
    // crossings into the core clock
    spcr_sync #(
        .WIDTH(3),
        .RST_VAL(3'h4)
    ) u_sync_core (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d({i_csb_n, i_update, srst_tgl_r}),
        .o_q({idle_s, upd_s, tgl_s})
    );

    // edge detectors on the synchronised levels
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            upd_d_r <= 1'h0;
            tgl_d_r <= 1'h0;
        end else begin
            upd_d_r <= upd_s;
            tgl_d_r <= tgl_s;
        end
    end

    // ==========================================
    // update request waits for an idle link; a new request wins over the clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            upd_pend_r <= 1'h0;
        end else if (upd_s && !upd_d_r) begin
            upd_pend_r <= 1'h1;
        end else if (idle_s || (tgl_s != tgl_d_r)) begin
            upd_pend_r <= 1'h0;
        end
    end

    // ==========================================
    // active bank; copying only while idle keeps the buffer words steady
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            user_act_r <= {USER_COUNT{`SPCR_USER_RESET}};
        end else if (tgl_s != tgl_d_r) begin
            user_act_r <= {USER_COUNT{`SPCR_USER_RESET}};
        end else if (upd_pend_r && idle_s) begin
            user_act_r <= user_buf_r;
        end
    end

    // one-cycle soft reset pulse for the rest of the device
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            soft_reset_r <= 1'h0;
        end else begin
            soft_reset_r <= (tgl_s != tgl_d_r);
        end
    end

    assign o_user_active = user_act_r;
    assign o_soft_reset = soft_reset_r;

endmodule

// ===== tb/spcr_chk.sv
// Purpose: port checks of spcr_top
// Assumes: bound to spcr_top, link clock may stop between frames
// Notes: small counters give every wait a bound
`timescale 1ns/1ns
module spcr_chk #(
    parameter int USER_COUNT = 4
) (
    // clocks and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sclk,
    // link pins
    input wire logic i_csb_n,
    input wire logic i_data_pin_in,
    input wire logic o_data_pin_out,
    input wire logic o_data_pin_oe,
    input wire logic o_serial_out,
    input wire logic o_serial_out_oe,
    // core side
    input wire logic i_i2c_mode,
    input wire logic i_update,
    input wire logic [USER_COUNT*8-1:0] o_user_active,
    input wire logic o_soft_reset
);
    // ==========================================
    // cycles since a legal cause of an active bank change
    logic [3:0] quiet_r;
    logic [4:0] bit_cnt_r;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) quiet_r <= 4'hf;
        else if (i_update || o_soft_reset || !i_csb_n) quiet_r <= 4'h0;
        else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
    end
    // link edges in the frame, cleared as the frame ends
    always_ff @(posedge i_sclk or posedge i_csb_n or negedge i_rstn) begin
        if (!i_rstn || i_csb_n) bit_cnt_r <= 5'h00;
        else if (bit_cnt_r != 5'h1f) bit_cnt_r <= bit_cnt_r + 5'h01;
    end

    // ==========================================
    // assertions
    property p_oe_excl; @(posedge i_clk) disable iff (!i_rstn) !(o_data_pin_oe && o_serial_out_oe);
    endproperty
    a_oe_excl: assert property (p_oe_excl) else $error("both outputs driven");
    property p_idle_quiet; @(posedge i_clk) disable iff (!i_rstn) i_csb_n |-> !o_data_pin_oe && !o_serial_out_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pin driven outside a frame");
    property p_oe_late; @(posedge i_sclk) disable iff (!i_rstn) (o_data_pin_oe || o_serial_out_oe) |-> bit_cnt_r >= 5'h10;
    endproperty
    a_oe_late: assert property (p_oe_late) else $error("read drive before instruction end");
    property p_srst_single; @(posedge i_clk) disable iff (!i_rstn) o_soft_reset |=> !o_soft_reset [*4];
    endproperty
    a_srst_single: assert property (p_srst_single) else $error("soft reset pulse too long");
    property p_srst_clears; @(posedge i_clk) disable iff (!i_rstn) o_soft_reset |-> ##[0:1] (o_user_active == '0);
    endproperty
    a_srst_clears: assert property (p_srst_clears) else $error("active bank kept on soft reset");
    property p_active_cause; @(posedge i_clk) disable iff (!i_rstn) $changed(o_user_active) |-> quiet_r < 4'h6;
    endproperty
    a_active_cause: assert property (p_active_cause) else $error("active bank changed without update");
    property p_srst_link; @(posedge i_clk) disable iff (!i_rstn) o_soft_reset |-> quiet_r < 4'h8;
    endproperty
    a_srst_link: assert property (p_srst_link) else $error("soft reset without link activity");
    property p_reset_quiet; @(posedge i_clk) disable iff (!i_rstn)
        $rose(i_rstn) |-> o_user_active == '0 && !o_soft_reset && !o_data_pin_oe && !o_serial_out_oe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not at defaults");
endmodule

bind spcr_top spcr_chk #(.USER_COUNT(USER_COUNT)) u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(i_sclk),
    .i_csb_n(i_csb_n), .i_data_pin_in(i_data_pin_in), .o_data_pin_out(o_data_pin_out),
    .o_data_pin_oe(o_data_pin_oe), .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
    .i_i2c_mode(i_i2c_mode), .i_update(i_update), .o_user_active(o_user_active), .o_soft_reset(o_soft_reset));

// ===== tb/spcr_host.sv
// Purpose: host controller on the serial link
// Assumes: device samples rising edges and drives on falling edges
// Notes: link clock stands low between frames
`timescale 1ns/1ns
module spcr_host (
    // link towards the device
    output logic o_sclk,
    output logic o_csb_n,
    output logic o_data,
    // device pins
    input wire logic i_data_out,
    input wire logic i_data_oe,
    input wire logic i_ser_out,
    input wire logic i_ser_oe
);
    logic drv;
    logic d;
    logic park;
    // released wire toggles so a missing driver never reads as a held value
    assign o_data = drv ? d : (i_data_oe ? i_data_out : park);
    always @(posedge o_sclk) park <= ~park;
    initial begin
        o_sclk = 1'b0;
        o_csb_n = 1'b1;
        d = 1'b0;
        drv = 1'b1;
        park = 1'b0;
    end
    // one frame: instruction then nb bytes, byte k in wd or q at [8k+7:8k]
    task automatic frame(input logic rd, input logic [12:0] a, input logic lsb, input logic ser,
                         input int nb, input logic [31:0] wd, output logic [31:0] q);
        logic [15:0] ins;
        int i;
        int n;
        int j;
        ins = {rd, 2'b00, a};
        q = '0;
        o_csb_n = 1'b0;
        // odd lead-in keeps link edges off the core clock edges
        #27;
        for (i = 0; i < 16 + 8 * nb; i++) begin
            n = i < 16 ? 0 : i - 16;
            j = 8 * (n / 8) + (lsb ? n % 8 : 7 - n % 8);
            drv = !rd || i < 16;
            d = i < 16 ? ins[lsb ? i : 15 - i] : wd[j];
            #24;
            if (rd && i >= 16) q[j] = ser ? (i_ser_oe ? i_ser_out : 1'bx) : o_data;
            o_sclk = 1'b1;
            #24;
            o_sclk = 1'b0;
        end
        #24;
        o_csb_n = 1'b1;
        drv = 1'b1;
        #45;
    endtask
endmodule

// ===== tb/spcr_tb_top.sv
// Purpose: self-checking bench of spcr_top
// Assumes: host model drives the link at a 48 ns period
// Notes: expected values come from the register layout alone
`timescale 1ns/1ns
`include "spcr_defines.svh"
module spcr_tb_top;
    import spcr_pkg::*;
    localparam logic [7:0] REV = 8'h3c;  // arbitrary value
    localparam logic [7:0] VAR = 8'h96;  // arbitrary value
    logic clk, rstn, sclk, csb_n, din, dout, doe, sout, soe, i2c, upd, srst, cur_lsb, cur_ser;
    logic [31:0] act;
    logic [31:0] q;
    int bad_count, samples_checked, srst_seen, cycles, s0;
    spcr_top #(.USER_COUNT(4), .REVISION_ID(REV), .VARIANT_CODE(VAR)) dut (.i_clk(clk), .i_rstn(rstn),
        .i_sclk(sclk), .i_csb_n(csb_n), .i_data_pin_in(din), .o_data_pin_out(dout), .o_data_pin_oe(doe),
        .o_serial_out(sout), .o_serial_out_oe(soe), .i_i2c_mode(i2c), .i_update(upd),
        .o_user_active(act), .o_soft_reset(srst));
    spcr_host host (.o_sclk(sclk), .o_csb_n(csb_n), .o_data(din), .i_data_out(dout), .i_data_oe(doe),
        .i_ser_out(sout), .i_ser_oe(soe));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // soft reset pulses and the hang guard
    always @(posedge clk) begin
        if (srst === 1'b1) srst_seen++;
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            close_out();
        end
    end
    // ==========================================
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [12:0] a, input int nb, input logic [31:0] wd);
        host.frame(1'b0, a, cur_lsb, cur_ser, nb, wd, q);
    endtask
    task automatic rd(input logic [12:0] a, input int nb);
        host.frame(1'b1, a, cur_lsb, cur_ser, nb, 32'h0, q);
    endtask
    // config byte with the low nibble mirroring the high one
    function automatic logic [31:0] cfg(logic d, logic o, logic s);
        return {24'h0, d, o, s, 2'b00, s, o, d};
    endfunction
    task automatic pulse_update();
        @(negedge clk) upd = 1'b1;
        repeat (4) @(negedge clk);
        upd = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    // ==========================================
    // scenarios
    task automatic t_defaults();
        rd(`SPCR_ADDR_CONFIG, 1); chk("config", cfg(0, 0, 0), q);
        rd(`SPCR_ADDR_REVISION, 1); chk("revision", {24'h0, REV}, q);
        rd(`SPCR_ADDR_VARIANT, 1); chk("variant", {24'h0, VAR}, q);
        rd(`SPCR_ADDR_BANKSEL, 1); chk("bank select", 32'h0, q);
        rd(13'h07ff, 1); chk("unmapped", 32'h0, q);
    endtask
    task automatic t_readonly();
        wr(`SPCR_ADDR_REVISION, 1, 32'hff);
        wr(`SPCR_ADDR_VARIANT, 1, 32'hff);
        rd(`SPCR_ADDR_REVISION, 1); chk("revision kept", {24'h0, REV}, q);
        rd(`SPCR_ADDR_VARIANT, 1); chk("variant kept", {24'h0, VAR}, q);
        wr(`SPCR_ADDR_BANKSEL, 1, 32'hff);
        rd(`SPCR_ADDR_BANKSEL, 1); chk("bank select unused", 32'h01, q);
        wr(`SPCR_ADDR_BANKSEL, 1, 32'h00);
    endtask
    task automatic t_bank();
        wr(`SPCR_ADDR_USER_BASE, 1, 32'ha5);
        repeat (8) @(negedge clk);
        chk("active before update", 32'h0, act);
        rd(`SPCR_ADDR_USER_BASE, 1); chk("buffer", 32'ha5, q);
        wr(`SPCR_ADDR_BANKSEL, 1, 32'h01);
        rd(`SPCR_ADDR_USER_BASE, 1); chk("active read", 32'h0, q);
        pulse_update();
        chk("active after update", 32'ha5, act);
        rd(`SPCR_ADDR_USER_BASE, 1); chk("active read", 32'ha5, q);
        wr(`SPCR_ADDR_BANKSEL, 1, 32'h00);
    endtask
    // msb first: stream steps down, then lsb first: stream steps up
    task automatic t_order();
        wr(13'h0011, 2, 32'h773c);
        rd(13'h0010, 1); chk("msb stream", 32'h77, q);
        rd(13'h0011, 2); chk("msb stream read", 32'h773c, q);
        pulse_update();
        chk("active two bytes", 32'h3c77, act);
        wr(`SPCR_ADDR_CONFIG, 1, cfg(0, 1, 0));
        cur_lsb = 1'b1;
        rd(`SPCR_ADDR_CONFIG, 1); chk("config lsb", cfg(0, 1, 0), q);
        wr(13'h0012, 2, 32'h9618);
        rd(13'h0013, 1); chk("lsb stream", 32'h96, q);
        rd(13'h0012, 2); chk("lsb stream read", 32'h9618, q);
    endtask
    task automatic t_dir();
        wr(`SPCR_ADDR_CONFIG, 1, 32'hdb);
        cur_ser = 1'b1;
        rd(`SPCR_ADDR_CONFIG, 1); chk("config unused bits", 32'hc3, q);
        rd(`SPCR_ADDR_VARIANT, 1); chk("variant serial out", {24'h0, VAR}, q);
        wr(`SPCR_ADDR_CONFIG, 1, 32'h00);
        cur_ser = 1'b0;
        cur_lsb = 1'b0;
    endtask
    task automatic t_soft();
        wr(`SPCR_ADDR_BANKSEL, 1, 32'h01);
        s0 = srst_seen;
        wr(`SPCR_ADDR_CONFIG, 1, cfg(1, 0, 1));
        cur_ser = 1'b1;
        rd(`SPCR_ADDR_CONFIG, 1); chk("config after soft reset", cfg(1, 0, 0), q);
        repeat (10) @(negedge clk);
        chk("soft reset pulses", 32'h1, srst_seen - s0);
        chk("active cleared", 32'h0, act);
        rd(`SPCR_ADDR_BANKSEL, 1); chk("bank select cleared", 32'h0, q);
        rd(`SPCR_ADDR_USER_BASE, 1); chk("buffer cleared", 32'h0, q);
        wr(`SPCR_ADDR_CONFIG, 1, 32'h00);
        cur_ser = 1'b0;
    endtask
    // second reset with the port strapped to i2c
    task automatic t_i2c();
        @(negedge clk) rstn = 1'b0;
        i2c = 1'b1;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        rd(`SPCR_ADDR_CONFIG, 1);
        wr(`SPCR_ADDR_CONFIG, 1, cfg(0, 1, 0));
        wr(`SPCR_ADDR_USER_BASE, 2, 32'h2d4b);
        rd(13'h0011, 1); chk("i2c stream", 32'h2d, q);
        rd(`SPCR_ADDR_USER_BASE, 2); chk("i2c stream read", 32'h2d4b, q);
        wr(`SPCR_ADDR_CONFIG, 1, cfg(0, 1, 1));
        rd(`SPCR_ADDR_CONFIG, 1); chk("i2c soft reset bit", 32'h0, q & 32'h24);
        rd(`SPCR_ADDR_USER_BASE, 1); chk("i2c buffer cleared", 32'h0, q);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        rstn = 1'b0;
        upd = 1'b0;
        i2c = 1'b0;
        {bad_count, samples_checked, srst_seen, cycles} = '0;
        {cur_lsb, cur_ser} = 2'b00;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_defaults();
        t_readonly();
        t_bank();
        t_order();
        t_dir();
        t_soft();
        t_i2c();
        close_out();
    end
endmodule
